// >>> bsis_sequencer.sv
`timescale 1ns/100ps
module bsis_sequencer #(
	parameter int MULTI_CYCLES = 8
)
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic clk_en,
	input wire logic second_timing_pulse,
	input wire logic [7:0] data_in,
	input wire logic [7:0] acc_value,
	input wire bsis_pkg::bsis_flags_t flags,
	input wire bsis_pkg::bsis_req_t requests,
	input wire logic counter_running,
	output logic [15:0] address,
	output logic memory_read_strobe,
	output logic memory_write_strobe,
	output logic data_oe,
	output logic request_ack,
	output logic toggle_output_enable,
	output logic scratch_clobber,
	output logic [7:0] opcode
);

	// ==========================================================
	// State and decode.
	bsis_pkg::bsis_state_t state;
	bsis_pkg::bsis_state_t next_state;
	logic [15:0] pc;
	logic [15:0] next_pc;
	logic [7:0] hi_byte;
	logic [7:0] sub_op;
	logic [3:0] multi_cnt;
	bsis_pkg::bsis_flags_t fsamp;
	logic [2:0] tp_sync;
	logic tp_level;

	// Pin input: a change counts when the second and third stages agree.
	// The agreed level is kept so that a glitch caught by one stage never counts.
	wire tp_rise = tp_sync[1] & tp_sync[2] & ~tp_level;
	wire is_idle = (opcode == bsis_pkg::OP_IDLE);
	wire is_short_br = (opcode[7:4] == bsis_pkg::OP_SHORT_BR_HI)
		&& (opcode != bsis_pkg::OP_SHORT_SKIP);
	wire is_short_skip = (opcode == bsis_pkg::OP_SHORT_SKIP);
	wire is_long = (opcode[7:4] == bsis_pkg::OP_LONG_HI);
	wire long_skip = is_long && opcode[2] && (opcode != bsis_pkg::OP_NOP);
	wire is_long_br = is_long && !opcode[2];
	wire is_prefix = (opcode == bsis_pkg::OP_PREFIX);
	wire is_irq_br = (sub_op == bsis_pkg::OP_BR_CNT_IRQ) || (sub_op == bsis_pkg::OP_BR_EXT_IRQ);
	wire is_cnt_br = (sub_op == bsis_pkg::OP_BR_CNT_IRQ);
	wire is_clobber = (sub_op[7:4] == bsis_pkg::OP_CALL_HI)
		|| (sub_op[7:4] == bsis_pkg::OP_RET_HI) || (sub_op == bsis_pkg::OP_SAVE_MULT);
	wire irq_wake = requests.irq && flags.master_irq_enable
		&& (flags.counter_irq_enable || flags.external_irq_enable);
	wire any_req = irq_wake || requests.dma_in || requests.dma_out;

	// The first execute cycle decides on live flags; later cycles use the copy taken then.
	bsis_pkg::bsis_flags_t cur_flags;
	always_comb
	begin
		cur_flags = fsamp;
		if (state == bsis_pkg::BSIS_EXEC1)
		begin
			cur_flags = flags;
			cur_flags.zero_acc = (acc_value == 8'h00);
		end
	end

	// Base condition on the low two opcode bits, bit 3 inverts it.
	logic base_cond;
	always_comb
	begin
		case (opcode[1:0])
			2'b00: base_cond = 1'b1;
			2'b01: base_cond = cur_flags.q_out;
			2'b10: base_cond = cur_flags.zero_acc;
			2'b11: base_cond = cur_flags.carry_flag;
			default: base_cond = 1'b0;
		endcase
	end

	// Short-branch conditions including the four flag inputs.
	logic short_cond;
	always_comb
	begin
		if (opcode[2])
			short_cond = cur_flags.external_flag_inputs[opcode[1:0]] ^ opcode[3];
		else
			short_cond = base_cond ^ opcode[3];
	end

	// Long branch and long skip share the condition set, except OP_SKIP_IRQ_EN, which tests the master enable; skip codes invert bit 3.
	wire long_br_cond = base_cond ^ opcode[3];
	wire long_skip_cond = (opcode == bsis_pkg::OP_SKIP_IRQ_EN) ? cur_flags.master_irq_enable
		: (base_cond ^ ~opcode[3]);
	wire irq_br_cond = is_cnt_br ? fsamp.counter_irq_latch : fsamp.external_irq_latch;
	wire multi_done = (multi_cnt == 4'(MULTI_CYCLES - 1));

	always_comb
	begin
		next_state = state;
		next_pc = pc;
		case (state)
			bsis_pkg::BSIS_FETCH:
			begin
				next_pc = pc + 16'h0001;
				if (any_req)
					next_state = bsis_pkg::BSIS_SERVICE;
				else
					next_state = bsis_pkg::BSIS_EXEC1;
			end
			bsis_pkg::BSIS_EXEC1:
			begin
				if (is_idle)
					next_state = tp_rise ? bsis_pkg::BSIS_IDLE : state;
				else if (is_prefix)
					next_state = bsis_pkg::BSIS_FETCH2;
				else if (is_short_br)
				begin
					next_pc = short_cond ? {pc[15:8], data_in} : pc + 16'h0001;
					next_state = bsis_pkg::BSIS_FETCH;
				end
				else if (is_short_skip)
				begin
					next_pc = pc + 16'h0001;
					next_state = bsis_pkg::BSIS_FETCH;
				end
				else if (is_long)
				begin
					if (is_long_br)
						next_pc = pc + 16'h0001;
					next_state = bsis_pkg::BSIS_EXEC2;
				end
				else
					next_state = bsis_pkg::BSIS_FETCH;
			end
			bsis_pkg::BSIS_EXEC2:
			begin
				next_state = bsis_pkg::BSIS_FETCH;
				if (long_skip)
					next_pc = long_skip_cond ? pc + 16'h0002 : pc;
				else if (is_long_br && long_br_cond)
					next_pc = {hi_byte, data_in};
				else if (is_long_br)
					next_pc = pc + 16'h0001;
				else
					next_pc = pc;
			end
			bsis_pkg::BSIS_FETCH2:
			begin
				next_pc = pc + 16'h0001;
				next_state = bsis_pkg::BSIS_MULTI;
			end
			bsis_pkg::BSIS_MULTI:
			begin
				// Service of requests is held off until this ends.
				if (is_irq_br)
				begin
					next_pc = irq_br_cond ? {pc[15:8], data_in} : pc + 16'h0001;
					next_state = bsis_pkg::BSIS_FETCH;
				end
				else if (multi_done)
					next_state = bsis_pkg::BSIS_FETCH;
			end
			bsis_pkg::BSIS_IDLE:
			begin
				if (any_req)
					next_state = bsis_pkg::BSIS_SERVICE;
			end
			bsis_pkg::BSIS_SERVICE:
				next_state = bsis_pkg::BSIS_FETCH;
			default:
				next_state = bsis_pkg::BSIS_FETCH;
		endcase
	end

	// ==========================================================
	// Registers.
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state <= bsis_pkg::BSIS_FETCH;
			pc <= bsis_pkg::PC_RESET;
			tp_sync <= 3'h0;
			tp_level <= 1'b0;
			opcode <= 8'h00;
			sub_op <= 8'h00;
			hi_byte <= 8'h00;
			multi_cnt <= 4'h0;
			fsamp <= '0;
			toggle_output_enable <= 1'b0;
		end
		else if (clk_en)
		begin
			tp_sync <= {tp_sync[1:0], second_timing_pulse};
			if (tp_sync[1] == tp_sync[2])
				tp_level <= tp_sync[2];
			state <= next_state;
			pc <= next_pc;
			if (state == bsis_pkg::BSIS_FETCH)
				opcode <= data_in;
			if (state == bsis_pkg::BSIS_FETCH2)
				sub_op <= data_in;
			if (state == bsis_pkg::BSIS_EXEC1)
			begin
				fsamp <= flags;
				fsamp.zero_acc <= (acc_value == 8'h00);
				hi_byte <= data_in;
			end
			multi_cnt <= (state == bsis_pkg::BSIS_MULTI) ? multi_cnt + 4'h1 : 4'h0;
			if (state == bsis_pkg::BSIS_MULTI && is_cnt_br && irq_br_cond)
				toggle_output_enable <= 1'b0;
			else if (state == bsis_pkg::BSIS_FETCH2
				&& data_in == bsis_pkg::OP_COUNTER_LOAD && !counter_running)
				toggle_output_enable <= 1'b0;
			else if (state == bsis_pkg::BSIS_FETCH2 && data_in == bsis_pkg::OP_TOGGLE_ENABLE)
				toggle_output_enable <= 1'b1;
		end
	end

	// ==========================================================
	// Outputs; idle freezes the address and floats the data bus.
	wire idle_now = (state == bsis_pkg::BSIS_IDLE);
	assign address = pc;
	// Operand bytes are read in the execute cycles other than BSIS_EXEC1 of OP_IDLE, so the strobe is low there too.
	wire exec_read = (state == bsis_pkg::BSIS_EXEC1 && !is_idle)
		|| state == bsis_pkg::BSIS_EXEC2 || state == bsis_pkg::BSIS_MULTI;
	assign memory_read_strobe = idle_now ? 1'b1 : ~(state == bsis_pkg::BSIS_FETCH
		|| state == bsis_pkg::BSIS_FETCH2 || exec_read);
	assign memory_write_strobe = 1'b1;
	assign data_oe = 1'b0;
	assign request_ack = (state == bsis_pkg::BSIS_SERVICE);
	assign scratch_clobber = (state == bsis_pkg::BSIS_MULTI) && is_clobber;

	a_idle_strobes: assert property (@(posedge ref_clk) disable iff (!rstn)
		idle_now |-> memory_read_strobe && memory_write_strobe && !data_oe)
		else $error("idle strobes wrong");
	a_idle_exit: assert property (@(posedge ref_clk) disable iff (!rstn)
		idle_now && clk_en && !any_req |=> idle_now)
		else $error("idle left without request");
	a_idle_wake: assert property (@(posedge ref_clk) disable iff (!rstn)
		idle_now && clk_en && requests.irq && !flags.master_irq_enable
		&& !requests.dma_in && !requests.dma_out |=> idle_now)
		else $error("masked interrupt woke idle");
	a_long_three: assert property (@(posedge ref_clk) disable iff (!rstn)
		state == bsis_pkg::BSIS_EXEC1 && is_long && clk_en && !is_idle
		|=> state == bsis_pkg::BSIS_EXEC2)
		else $error("long op lacks second execute");
	a_skip_pc: assert property (@(posedge ref_clk) disable iff (!rstn)
		state == bsis_pkg::BSIS_EXEC1 && is_short_skip && clk_en
		|=> pc == $past(pc) + 16'h0001)
		else $error("short skip pc wrong");
	a_short_page: assert property (@(posedge ref_clk) disable iff (!rstn)
		state == bsis_pkg::BSIS_EXEC1 && is_short_br && clk_en
		|=> pc[15:8] == $past(pc[15:8]))
		else $error("short branch left page");
	a_long_skip_two: assert property (@(posedge ref_clk) disable iff (!rstn)
		state == bsis_pkg::BSIS_EXEC2 && long_skip && long_skip_cond && clk_en
		|=> pc == $past(pc) + 16'h0002)
		else $error("long skip pc wrong");
	a_prefix_defer: assert property (@(posedge ref_clk) disable iff (!rstn)
		state == bsis_pkg::BSIS_MULTI |-> !request_ack)
		else $error("request serviced mid prefix");
	a_nop_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
		state == bsis_pkg::BSIS_EXEC2 && opcode == bsis_pkg::OP_NOP && clk_en
		|=> pc == $past(pc))
		else $error("nop moved pc");
	a_long_target: assert property (@(posedge ref_clk) disable iff (!rstn)
		state == bsis_pkg::BSIS_EXEC2 && is_long_br && long_br_cond && clk_en
		|=> pc == {$past(hi_byte), $past(data_in)})
		else $error("long branch target wrong");
	a_long_fail: assert property (@(posedge ref_clk) disable iff (!rstn)
		state == bsis_pkg::BSIS_EXEC2 && is_long_br && !long_br_cond && clk_en
		|=> pc == $past(pc) + 16'h0001)
		else $error("failed long branch pc wrong");
	a_short_fail: assert property (@(posedge ref_clk) disable iff (!rstn)
		state == bsis_pkg::BSIS_EXEC1 && is_short_br && !short_cond && clk_en
		|=> pc == $past(pc) + 16'h0001)
		else $error("failed short branch pc wrong");
	a_idle_entry: assert property (@(posedge ref_clk) disable iff (!rstn)
		state == bsis_pkg::BSIS_EXEC1 && is_idle && tp_rise && clk_en
		|=> idle_now)
		else $error("idle not entered at pulse");
	a_toggle_clear: assert property (@(posedge ref_clk) disable iff (!rstn)
		state == bsis_pkg::BSIS_MULTI && is_cnt_br && irq_br_cond && clk_en
		|=> !toggle_output_enable)
		else $error("toggle enable not cleared");

endmodule : bsis_sequencer

// >>> bsis_pkg.sv
package bsis_pkg;

	// ==========================================================
	// Opcode classes.
	localparam logic [7:0] OP_IDLE = 8'h00;
	localparam logic [3:0] OP_SHORT_BR_HI = 4'h3;
	localparam logic [3:0] OP_LONG_HI = 4'hC;
	localparam logic [7:0] OP_SHORT_SKIP = 8'h38;
	localparam logic [7:0] OP_NOP = 8'hC4;
	localparam logic [7:0] OP_PREFIX = 8'h68;
	localparam logic [7:0] OP_BR_CNT_IRQ = 8'h3E;
	localparam logic [7:0] OP_BR_EXT_IRQ = 8'h3F;
	localparam logic [7:0] OP_COUNTER_LOAD = 8'h06;
	localparam logic [3:0] OP_CALL_HI = 4'h8;
	localparam logic [3:0] OP_RET_HI = 4'h9;
	localparam logic [7:0] OP_SAVE_MULT = 8'h76;
	localparam logic [7:0] OP_TOGGLE_ENABLE = 8'h09;
	localparam logic [7:0] OP_SKIP_IRQ_EN = 8'hCC;

	// ==========================================================
	// Reset values.
	localparam logic [15:0] PC_RESET = 16'h0000;

	typedef enum logic [6:0] {
		BSIS_FETCH = 7'h01,
		BSIS_FETCH2 = 7'h02,
		BSIS_EXEC1 = 7'h04,
		BSIS_EXEC2 = 7'h08,
		BSIS_IDLE = 7'h10,
		BSIS_MULTI = 7'h20,
		BSIS_SERVICE = 7'h40
	} bsis_state_t;

	typedef struct packed {
		logic zero_acc;
		logic carry_flag;
		logic q_out;
		logic [3:0] external_flag_inputs;
		logic counter_irq_latch;
		logic external_irq_latch;
		logic master_irq_enable;
		logic counter_irq_enable;
		logic external_irq_enable;
	} bsis_flags_t;

	typedef struct packed {
		logic irq;
		logic dma_in;
		logic dma_out;
	} bsis_req_t;

endpackage : bsis_pkg

// >>> bsis_mem_model.sv
`timescale 1ns/100ps
module bsis_mem_model
(
	input wire logic ref_clk,
	input wire logic [15:0] address,
	input wire logic memory_read_strobe,
	output logic [7:0] data_in
);
	logic [7:0] mem [0:65535];
	logic [7:0] last;

	initial
	begin
		foreach (mem[i])
			mem[i] = 8'hC4;
	end

	// ==========================================================
	// Read port.
	// A released bus shows the complement of the last byte, so a stale value is never trusted.
	always_ff @(posedge ref_clk)
		if (!memory_read_strobe)
			last <= mem[address];
	assign data_in = memory_read_strobe ? ~last : mem[address];
endmodule : bsis_mem_model

// >>> branch_skip_idle_sequencer_tb.sv
`timescale 1ns/100ps
module branch_skip_idle_sequencer_tb;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic clk_en = 1'b1;
	logic second_timing_pulse = 1'b0;
	logic [7:0] data_in;
	logic [7:0] acc_value = 8'h01;
	bsis_pkg::bsis_flags_t flags = '0;
	bsis_pkg::bsis_req_t requests = '0;
	logic counter_running = 1'b0;
	logic [15:0] address;
	logic memory_read_strobe;
	logic memory_write_strobe;
	logic data_oe;
	logic request_ack;
	logic toggle_output_enable;
	logic scratch_clobber;
	logic [7:0] opcode;
	int failures = 0;
	int num_checks = 0;
	int ack_cnt = 0;
	int bad_ack = 0;
	int clob_cnt = 0;

	bsis_sequencer #(.MULTI_CYCLES(2)) u_bsis_sequencer (.ref_clk(ref_clk), .rstn(rstn),
		.clk_en(clk_en), .second_timing_pulse(second_timing_pulse), .data_in(data_in),
		.acc_value(acc_value), .flags(flags), .requests(requests),
		.counter_running(counter_running), .address(address),
		.memory_read_strobe(memory_read_strobe), .memory_write_strobe(memory_write_strobe),
		.data_oe(data_oe), .request_ack(request_ack),
		.toggle_output_enable(toggle_output_enable), .scratch_clobber(scratch_clobber),
		.opcode(opcode));

	bsis_mem_model u_bsis_mem_model (.ref_clk(ref_clk), .address(address),
		.memory_read_strobe(memory_read_strobe), .data_in(data_in));

	initial
	begin
		forever #2.5 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk)
	begin
		if (request_ack)
			ack_cnt++;
		if (request_ack && scratch_clobber)
			bad_ack++;
		if (scratch_clobber)
			clob_cnt++;
	end

	// ==========================================================
	// Helpers.
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : cyc

	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk16

	task automatic chk1(input logic got, input logic exp);
		chk16({15'h0000, got}, {15'h0000, exp});
	endtask : chk1

	task automatic put(input logic [15:0] a, input logic [23:0] v, input int n);
		for (int i = 0; i < n; i++)
			u_bsis_mem_model.mem[a + 16'(i)] = v[8 * (n - 1 - i) +: 8];
	endtask : put

	task automatic do_reset();
		rstn = 1'b0;
		cyc(4);
		rstn = 1'b1;
	endtask : do_reset

	task automatic test_done();
		$display("checks=%0d failures=%0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : test_done

	initial
	begin
		#5000;
		failures++;
		test_done();
	end

	// ==========================================================
	// Tests.
	initial
	begin
		flags.master_irq_enable = 1'b1;
		cyc(1);
		put(16'h0000, 24'hC01234, 3);
		put(16'h1234, 24'h003050, 2);
		put(16'h1250, 24'hC2AABB, 3);
		put(16'h1253, 24'h0038FF, 2);
		put(16'h1255, 24'h0000CC, 1);
		put(16'h1258, 24'h0000C4, 1);
		put(16'h1259, 24'h003270, 2);
		put(16'h125B, 24'h000000, 1);
		do_reset();
		chk1(toggle_output_enable, 1'b0);
		cyc(2);
		chk16(address, 16'h0002);
		cyc(1);
		chk16(address, 16'h1234);
		cyc(2);
		chk16(address, 16'h1250);
		cyc(3);
		chk16(address, 16'h1253);
		cyc(2);
		chk16(address, 16'h1255);
		cyc(3);
		chk16(address, 16'h1258);
		cyc(3);
		chk16(address, 16'h1259);
		cyc(2);
		chk16(address, 16'h125B);
		cyc(1);
		second_timing_pulse = 1'b1;
		cyc(8);
		chk1(memory_read_strobe, 1'b1);
		chk1(memory_write_strobe, 1'b1);
		chk1(data_oe, 1'b0);
		// Only the master enable is set, so the interrupt must not end idle.
		requests.irq = 1'b1;
		cyc(10);
		chk16(16'(ack_cnt), 16'h0000);
		flags.external_irq_enable = 1'b1;
		for (int i = 0; i < 20 && ack_cnt == 0; i++)
			cyc(1);
		chk1(ack_cnt > 0, 1'b1);
		requests.irq = 1'b0;
		put(16'h0000, 24'h006886, 2);
		do_reset();
		cyc(2);
		requests.irq = 1'b1;
		cyc(12);
		chk1(clob_cnt > 0, 1'b1);
		chk16(16'(bad_ack), 16'h0000);
		test_done();
	end
endmodule : branch_skip_idle_sequencer_tb
